// ==== src/dvm_pkg.sv ====
/*
 * Constants, field layout and carrier types of the DAC digital volume and mute stage.
 * Assumes one system clock. Samples arrive as signed two's complement words.
 */
package dvm_pkg;
   // =========================================================
   // Register offsets and reset values
   localparam logic [7:0] ADDR_MUTE_LINK  = 8'h40;
   localparam logic [7:0] ADDR_LEFT_GAIN  = 8'h41;
   localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h42;
   localparam logic [7:0] RST_MUTE_LINK   = 8'h0C;
   localparam logic [7:0] RST_GAIN        = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

   // =========================================================
   // Field positions in the mute and link register
   localparam int MUTE_L_BIT = 3;
   localparam int MUTE_R_BIT = 2;
   localparam int LINK_LSB   = 0;

   localparam logic [1:0] LINK_INDEP_A = 2'h0;
   localparam logic [1:0] LINK_R_TO_L  = 2'h1;
   localparam logic [1:0] LINK_L_TO_R  = 2'h2;
   localparam logic [1:0] LINK_INDEP_B = 2'h3;

   localparam logic [1:0] STEP_EVERY  = 2'h0;
   localparam logic [1:0] STEP_SECOND = 2'h1;
   localparam logic [1:0] STEP_NONE   = 2'h2;

   // =========================================================
   // Gain code range in half-dB steps
   localparam logic signed [7:0] GAIN_MAX   = 8'sh30;
   localparam logic signed [7:0] GAIN_MIN   = 8'sh81;
   localparam logic signed [8:0] GAIN_TOP9  = 9'sh030;
   localparam logic [7:0]        STEPS_OCT  = 8'h0C;
   localparam int                UNITY_SHR  = 11;
   localparam int                SAMPLE_W   = 24;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } dvm_pair_s;

   typedef struct packed {
      logic [7:0]        ctrl;
      logic signed [7:0] gain_l;
      logic signed [7:0] gain_r;
      logic signed [7:0] cur_l;
      logic signed [7:0] cur_r;
      logic              skip;
      dvm_pair_s         out;
      logic              out_valid;
      logic [7:0]        rdata;
   } dvm_state_s;

   // Fraction 2^(-r/12) in Q15, one entry per half-dB step within 6 dB
   function automatic logic [15:0] frac_q15(input logic [7:0] r);
      unique case (r)
         8'h00: frac_q15 = 16'h8000;
         8'h01: frac_q15 = 16'h78D1;
         8'h02: frac_q15 = 16'h7209;
         8'h03: frac_q15 = 16'h6BA2;
         8'h04: frac_q15 = 16'h6598;
         8'h05: frac_q15 = 16'h5FE4;
         8'h06: frac_q15 = 16'h5A82;
         8'h07: frac_q15 = 16'h556E;
         8'h08: frac_q15 = 16'h50A3;
         8'h09: frac_q15 = 16'h4C1C;
         8'h0A: frac_q15 = 16'h47D6;
         default: frac_q15 = 16'h43CE;
      endcase
   endfunction : frac_q15
endpackage : dvm_pkg

// ==== src/dvm_top.sv ====
/*
 * Digital volume, soft-step and mute stage for a stereo DAC sample stream.
 * Assumes samples and register strobes come from logic on sys_clk; step mode and
 * compressor enables are driven by neighbouring register logic on the same clock.
 */
// What this block does
// RL1: Host writes zeros to upper control bits.
// RL2: Left mute bit D3 silences left.
// RL3: Right mute bit D2 silences right.
// RL4: Link 00 or 11 keeps gains independent.
// RL5: Link 01 applies right gain to left.
// RL6: Link 10 applies left gain to right.
// RL7: Compressor active forces independent gains.
// RL8: Left gain signed half-dB, +24 to -63.5.
// RL9: Code zero is unity, FF is -0.5 dB.
// RL10: Right gain uses the same encoding.
// RL11: Host avoids unsupported gain codes.
// RL12: Soft step per one, two samples, or immediate.
// RL13: Per-channel compressor enables from D6, D5.
// RL14: Muted channel outputs zeros, gains kept.
`timescale 1ns/1ps
module dvm_top (
   input  wire logic               sys_clk,       // System clock, 50 MHz
   input  wire logic               srst,          // Synchronous reset, active high
   input  wire logic               reg_wr_en,     // Register write strobe
   input  wire logic               reg_rd_en,     // Register read strobe
   input  wire logic [7:0]         reg_addr,      // Register offset
   input  wire logic [7:0]         reg_wdata,     // Register write data
   output logic      [7:0]         reg_rdata,     // Register read data
   input  wire logic [1:0]         step_mode,     // Soft-step selection
   input  wire logic               drc_en_l,      // Compressor active, left
   input  wire logic               drc_en_r,      // Compressor active, right
   input  wire logic               in_valid,      // Sample pair strobe
   input  wire dvm_pkg::dvm_pair_s in_sample,     // Sample pair in
   output logic                    out_valid,     // Sample pair out strobe
   output dvm_pkg::dvm_pair_s      out_sample     // Scaled sample pair
);

   // =========================================================
   // Helpers
   function automatic logic signed [7:0] clamp_code(input logic signed [7:0] g);
      // Unsupported codes are pinned to the nearest legal end
      if (g > dvm_pkg::GAIN_MAX) begin
         clamp_code = dvm_pkg::GAIN_MAX;
      end else if (g < dvm_pkg::GAIN_MIN) begin
         clamp_code = dvm_pkg::GAIN_MIN;
      end else begin
         clamp_code = g;
      end
   endfunction : clamp_code

   function automatic logic signed [dvm_pkg::SAMPLE_W-1:0] apply_gain(
      input logic signed [dvm_pkg::SAMPLE_W-1:0] s,
      input logic signed [7:0]                   g);
      logic signed [8:0]                    att;
      logic [7:0]                           oct;
      logic [7:0]                           rem;
      logic signed [dvm_pkg::SAMPLE_W+16:0] prod;
      logic signed [dvm_pkg::SAMPLE_W+16:0] lim_hi;
      logic signed [dvm_pkg::SAMPLE_W+16:0] lim_lo;
      // Attenuation from the +24 dB top, in half-dB steps
      att    = dvm_pkg::GAIN_TOP9 - 9'(signed'(clamp_code(g))); // RL8 RL10
      oct    = 8'(att[7:0] / dvm_pkg::STEPS_OCT);
      rem    = 8'(att[7:0] % dvm_pkg::STEPS_OCT);
      prod   = (s * $signed({1'b0, dvm_pkg::frac_q15(rem)})) >>> (dvm_pkg::UNITY_SHR + oct);
      lim_hi = (dvm_pkg::SAMPLE_W+17)'({1'b0, {(dvm_pkg::SAMPLE_W-1){1'b1}}});
      lim_lo = -lim_hi - 1;
      // Gain above unity can overflow; saturate rather than wrap
      if (prod > lim_hi) begin
         apply_gain = lim_hi[dvm_pkg::SAMPLE_W-1:0];
      end else if (prod < lim_lo) begin
         apply_gain = lim_lo[dvm_pkg::SAMPLE_W-1:0];
      end else begin
         apply_gain = prod[dvm_pkg::SAMPLE_W-1:0];
      end
   endfunction : apply_gain

   function automatic logic signed [7:0] step_toward(
      input logic signed [7:0] cur,
      input logic signed [7:0] tgt);
      if (cur < tgt) begin
         step_toward = cur + 8'sh01;
      end else if (cur > tgt) begin
         step_toward = cur - 8'sh01;
      end else begin
         step_toward = cur;
      end
   endfunction : step_toward

   // =========================================================
   // State
   dvm_pkg::dvm_state_s state_reg;
   dvm_pkg::dvm_state_s state_next;
   logic [1:0]          link;
   logic signed [7:0]   tgt_l;
   logic signed [7:0]   tgt_r;
   logic                do_step;

   always_comb begin
      link = state_reg.ctrl[dvm_pkg::LINK_LSB +: 2];
      // Compressor forces independent gains on its channel
      tgt_l = state_reg.gain_l; // RL4
      tgt_r = state_reg.gain_r; // RL4
      if (link == dvm_pkg::LINK_R_TO_L && !drc_en_l) begin // RL7 RL13
         tgt_l = state_reg.gain_r; // RL5
      end
      if (link == dvm_pkg::LINK_L_TO_R && !drc_en_r) begin // RL7 RL13
         tgt_r = state_reg.gain_l; // RL6
      end
   end

   always_comb begin
      state_next           = state_reg;
      state_next.out_valid = 1'b0;
      do_step              = 1'b0;

      // Register writes; upper control bits are stored as written
      if (reg_wr_en) begin // RL1
         unique case (reg_addr)
            dvm_pkg::ADDR_MUTE_LINK:  state_next.ctrl   = reg_wdata;
            dvm_pkg::ADDR_LEFT_GAIN:  state_next.gain_l = reg_wdata;
            dvm_pkg::ADDR_RIGHT_GAIN: state_next.gain_r = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd_en) begin
         unique case (reg_addr)
            dvm_pkg::ADDR_MUTE_LINK:  state_next.rdata = state_reg.ctrl;
            dvm_pkg::ADDR_LEFT_GAIN:  state_next.rdata = state_reg.gain_l;
            dvm_pkg::ADDR_RIGHT_GAIN: state_next.rdata = state_reg.gain_r;
            default:                  state_next.rdata = dvm_pkg::RDATA_UNMAPPED;
         endcase
      end

      if (in_valid) begin
         // Gain keeps tracking while muted, so unmute resumes at the live gain
         unique case (step_mode) // RL12
            dvm_pkg::STEP_EVERY: begin
               do_step         = 1'b1;
               state_next.skip = 1'b0;
            end
            dvm_pkg::STEP_SECOND: begin
               do_step         = state_reg.skip;
               state_next.skip = !state_reg.skip;
            end
            default: begin
               // Reserved code treated as immediate
               state_next.cur_l = tgt_l;
               state_next.cur_r = tgt_r;
               state_next.skip  = 1'b0;
            end
         endcase
         if (do_step) begin
            state_next.cur_l = step_toward(state_reg.cur_l, tgt_l); // RL12
            state_next.cur_r = step_toward(state_reg.cur_r, tgt_r); // RL12
         end
         // Updated live gain scales this pair, so immediate mode takes effect at once
         state_next.out_valid  = 1'b1;
         state_next.out.left   = apply_gain(in_sample.left, state_next.cur_l);  // RL9
         state_next.out.right  = apply_gain(in_sample.right, state_next.cur_r); // RL9
         if (state_reg.ctrl[dvm_pkg::MUTE_L_BIT]) begin
            state_next.out.left = '0; // RL2 RL14
         end
         if (state_reg.ctrl[dvm_pkg::MUTE_R_BIT]) begin
            state_next.out.right = '0; // RL3 RL14
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg        <= '0;
         state_reg.ctrl   <= dvm_pkg::RST_MUTE_LINK;
         state_reg.gain_l <= dvm_pkg::RST_GAIN;
         state_reg.gain_r <= dvm_pkg::RST_GAIN;
         state_reg.cur_l  <= dvm_pkg::RST_GAIN;
         state_reg.cur_r  <= dvm_pkg::RST_GAIN;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata  = state_reg.rdata;
   assign out_valid  = state_reg.out_valid;
   assign out_sample = state_reg.out;

   // =========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_second_mode_pair;
      in_valid && step_mode == dvm_pkg::STEP_SECOND && !state_reg.skip;
   endsequence

   a_mute_left_zero: assert property ( // RL2
      in_valid && state_reg.ctrl[dvm_pkg::MUTE_L_BIT] |=> out_valid && out_sample.left == '0)
      else $error("left mute did not silence");
   a_mute_right_zero: assert property ( // RL3
      in_valid && state_reg.ctrl[dvm_pkg::MUTE_R_BIT] |=> out_valid && out_sample.right == '0)
      else $error("right mute did not silence");
   a_link_indep_gain: assert property ( // RL4
      in_valid && step_mode == dvm_pkg::STEP_NONE && (link == dvm_pkg::LINK_INDEP_A ||
      link == dvm_pkg::LINK_INDEP_B) |=> state_reg.cur_l == $past(state_reg.gain_l) &&
      state_reg.cur_r == $past(state_reg.gain_r))
      else $error("independent gains not applied");
   a_link_right_left: assert property ( // RL5
      in_valid && step_mode == dvm_pkg::STEP_NONE && link == dvm_pkg::LINK_R_TO_L &&
      !drc_en_l |=> state_reg.cur_l == $past(state_reg.gain_r))
      else $error("right gain not used for left");
   a_link_left_right: assert property ( // RL6
      in_valid && step_mode == dvm_pkg::STEP_NONE && link == dvm_pkg::LINK_L_TO_R &&
      !drc_en_r |=> state_reg.cur_r == $past(state_reg.gain_l))
      else $error("left gain not used for right");
   a_drc_keeps_indep: assert property ( // RL7
      in_valid && step_mode == dvm_pkg::STEP_NONE && drc_en_l |=>
      state_reg.cur_l == $past(state_reg.gain_l))
      else $error("compressor did not force independent left gain");
   a_unity_passes: assert property ( // RL9
      in_valid && state_next.cur_l == 8'sh00 && !state_reg.ctrl[dvm_pkg::MUTE_L_BIT] |=>
      out_sample.left == $past(in_sample.left))
      else $error("unity gain altered sample");
   a_step_every_one: assert property ( // RL12
      in_valid && step_mode == dvm_pkg::STEP_EVERY && state_reg.cur_l < tgt_l |=>
      state_reg.cur_l == $past(state_reg.cur_l) + 8'sh01)
      else $error("soft step not one per sample");
   a_step_second_hold: assert property ( // RL12
      s_second_mode_pair |=> state_reg.cur_l == $past(state_reg.cur_l) && state_reg.skip)
      else $error("two-sample step moved early");
   a_mute_keeps_gain: assert property ( // RL14
      reg_wr_en && reg_addr == dvm_pkg::ADDR_MUTE_LINK |=> $stable(state_reg.gain_l) &&
      $stable(state_reg.gain_r))
      else $error("mute write changed gain words");

   // =========================================================
   // Register read-back
   sequence s_read_ctrl;
      reg_rd_en && reg_addr == dvm_pkg::ADDR_MUTE_LINK;
   endsequence

   sequence s_read_left;
      reg_rd_en && reg_addr == dvm_pkg::ADDR_LEFT_GAIN;
   endsequence

   sequence s_read_right;
      reg_rd_en && reg_addr == dvm_pkg::ADDR_RIGHT_GAIN;
   endsequence

   // A read in the same cycle as a write returns the old value
   a_read_ctrl_back: assert property ( // RL2
      s_read_ctrl |=> reg_rdata == $past(state_reg.ctrl))
      else $error("control read back wrong");

   a_read_left_back: assert property ( // RL8
      s_read_left |=> reg_rdata == $past(state_reg.gain_l))
      else $error("left gain read back wrong");

   a_read_right_back: assert property ( // RL10
      s_read_right |=> reg_rdata == $past(state_reg.gain_r))
      else $error("right gain read back wrong");

   a_read_unmapped: assert property ( // RL10
      reg_rd_en && reg_addr != dvm_pkg::ADDR_MUTE_LINK &&
      reg_addr != dvm_pkg::ADDR_LEFT_GAIN && reg_addr != dvm_pkg::ADDR_RIGHT_GAIN |=>
      reg_rdata == dvm_pkg::RDATA_UNMAPPED)
      else $error("unmapped read not zero");

   // =========================================================
   // Stream timing and right channel
   a_out_one_cycle: assert property ( // RL14
      in_valid |=> out_valid)
      else $error("output pulse missing");

   a_out_no_stray: assert property ( // RL14
      !in_valid |=> !out_valid)
      else $error("output pulse without input");

   a_unity_right: assert property ( // RL10
      in_valid && state_next.cur_r == 8'sh00 && !state_reg.ctrl[dvm_pkg::MUTE_R_BIT] |=>
      out_sample.right == $past(in_sample.right))
      else $error("unity gain altered right sample");

   a_drc_keeps_right: assert property ( // RL7
      in_valid && step_mode == dvm_pkg::STEP_NONE && drc_en_r |=>
      state_reg.cur_r == $past(state_reg.gain_r))
      else $error("compressor did not force independent right gain");

   // =========================================================
   // Soft-step pacing
   sequence s_second_mode_move;
      in_valid && step_mode == dvm_pkg::STEP_SECOND && state_reg.skip &&
      state_reg.cur_l < tgt_l;
   endsequence

   a_step_every_down: assert property ( // RL12
      in_valid && step_mode == dvm_pkg::STEP_EVERY && state_reg.cur_r > tgt_r |=>
      state_reg.cur_r == $past(state_reg.cur_r) - 8'sh01)
      else $error("soft step down not one per sample");

   a_step_second_move: assert property ( // RL12
      s_second_mode_move |=> state_reg.cur_l == $past(state_reg.cur_l) + 8'sh01 &&
      !state_reg.skip)
      else $error("two-sample step did not move");

   // Without a sample the live gain must not drift
   a_gain_hold_idle: assert property ( // RL12
      !in_valid |=> $stable(state_reg.cur_l) && $stable(state_reg.cur_r))
      else $error("live gain moved without a sample");
endmodule : dvm_top

// ==== test/dvm_src_model.sv ====
/*
 * Sample source standing in for the DAC processing path ahead of the stage.
 * Assumes one clock; go held high sends one pair per cycle.
 */
`timescale 1ns/1ps
module dvm_src_model (
   input  wire logic               sys_clk,   // Clock
   input  wire logic               go,        // Send a pair this cycle
   input  wire dvm_pkg::dvm_pair_s pair,      // Pair to send
   output logic                    in_valid,  // Pair strobe
   output dvm_pkg::dvm_pair_s      in_sample  // Pair out
);
   initial begin
      in_valid  = 1'b0;
      in_sample = '0;
   end
   // Data is inverted on each idle cycle, so a stale value differs from the last pair after an odd number of idle cycles
   always @(posedge sys_clk) begin
      in_valid  <= go;
      in_sample <= go ? pair : ~in_sample;
   end
endmodule : dvm_src_model

// ==== test/dvm_top_tb.sv ====
/*
 * Self-checking bench of the volume and mute stage: register tasks, sample pairs.
 * Assumes the source model beside it; step mode and compressor enables are plain levels.
 */
`timescale 1ns/1ps
module dvm_top_tb;
   localparam logic [23:0] L = 24'h001000;
   localparam logic [23:0] R = 24'hFFF000;
   logic               sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic               go = 1'b0, dl = 1'b0, dr = 1'b0, iv, ov;
   logic [7:0]         addr = 8'h00, wd = 8'h00, rdata;
   logic [1:0]         step = 2'h2;
   dvm_pkg::dvm_pair_s pair = '0, ins, outs;
   int                 error_cnt = 0, tests_run = 0;

   always #10 sys_clk = ~sys_clk;

   dvm_src_model i_dvm_src_model (.sys_clk(sys_clk), .go(go), .pair(pair), .in_valid(iv),
      .in_sample(ins));
   dvm_top i_dvm_top (.sys_clk(sys_clk), .srst(srst), .reg_wr_en(wr), .reg_rd_en(rd),
      .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .step_mode(step), .drc_en_l(dl),
      .drc_en_r(dr), .in_valid(iv), .in_sample(ins), .out_valid(ov), .out_sample(outs));

   // ==========================================================
   // Tasks
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk); wr <= 1'b1; addr <= a; wd <= d;
      @(posedge sys_clk); wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk); rd <= 1'b1; addr <= a;
      @(posedge sys_clk); rd <= 1'b0;
      #1 chk({40'h0, rdata}, {40'h0, exp});
   endtask : rd_reg

   // Gain codes used here are whole 6 dB multiples, so scaling is an exact shift
   function automatic logic [23:0] scl(input logic [23:0] s, input logic [7:0] g);
      int k;
      k = $signed(g) / 12;
      return k >= 0 ? 24'($signed(s) <<< k) : 24'($signed(s) >>> (-k));
   endfunction : scl

   task automatic smp(input logic [7:0] gl, input logic [7:0] gr, input logic ml,
                      input logic mr);
      @(posedge sys_clk); go <= 1'b1; pair <= {L, R};
      @(posedge sys_clk); go <= 1'b0;
      @(posedge sys_clk); #1;
      chk({47'h0, ov}, 48'h1);
      chk(outs, {ml ? 24'h0 : scl(L, gl), mr ? 24'h0 : scl(R, gr)});
   endtask : smp

   // Back-to-back pairs, one per cycle, no check
   task automatic send(input int n);
      @(posedge sys_clk); go <= 1'b1; pair <= {L, R};
      repeat (n) @(posedge sys_clk);
      go <= 1'b0;
   endtask : send

   // ==========================================================
   // Tests
   initial begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      rd_reg(8'h40, 8'h0C);
      rd_reg(8'h41, 8'h00);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h43, 8'h00);
      smp(8'h00, 8'h00, 1'b1, 1'b1);
      wr_reg(8'h40, 8'h00);
      smp(8'h00, 8'h00, 1'b0, 1'b0);
      $display("reset and unity test done");
      wr_reg(8'h41, 8'h0C);
      wr_reg(8'h42, 8'hF4);
      smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      wr_reg(8'h40, 8'h01);
      smp(8'hF4, 8'hF4, 1'b0, 1'b0);
      wr_reg(8'h40, 8'h02);
      smp(8'h0C, 8'h0C, 1'b0, 1'b0);
      wr_reg(8'h40, 8'h03);
      smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      wr_reg(8'h40, 8'h01);
      dl <= 1'b1;
      smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      wr_reg(8'h40, 8'h02);
      dl <= 1'b0;
      dr <= 1'b1;
      smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      dr <= 1'b0;
      $display("link test done");
      wr_reg(8'h40, 8'h08);
      smp(8'h0C, 8'hF4, 1'b1, 1'b0);
      wr_reg(8'h40, 8'h04);
      smp(8'h0C, 8'hF4, 1'b0, 1'b1);
      wr_reg(8'h40, 8'h00);
      smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      rd_reg(8'h41, 8'h0C);
      wr_reg(8'h41, 8'h30);
      wr_reg(8'h42, 8'hB8);
      smp(8'h30, 8'hB8, 1'b0, 1'b0);
      $display("mute and range test done");
      for (int m = 0; m < 2; m++) begin
         wr_reg(8'h41, 8'h00);
         wr_reg(8'h42, 8'h00);
         step <= 2'h2;
         smp(8'h00, 8'h00, 1'b0, 1'b0);
         step <= 2'(m);
         wr_reg(8'h41, 8'h0C);
         wr_reg(8'h42, 8'hF4);
         send(12 * (m + 1));
         smp(8'h0C, 8'hF4, 1'b0, 1'b0);
      end
      $display("soft step test done");
      close_out();
   end

   initial begin
      #1_000_000;
      error_cnt++;
      close_out();
   end
endmodule : dvm_top_tb
